/* edpq_params.svh */
// constants for the edge delay and pulse qualifier
`ifndef EDPQ_PARAMS_SVH
`define EDPQ_PARAMS_SVH
`define EDPQ_CODE_W        4
`define EDPQ_POL_BIT       3
`define EDPQ_CNT_W         22
`define EDPQ_START_TICKS   22'h0001F4
`define EDPQ_FILT_BASE     6
`define EDPQ_FILT_MULT     16
`define EDPQ_FILT_W        9
`define EDPQ_MASTER_MIN_NS 1000
`define EDPQ_CLK_NS        40
`define EDPQ_MIN_TICK_CYC  ((`EDPQ_MASTER_MIN_NS + `EDPQ_CLK_NS - 1) / `EDPQ_CLK_NS)
`endif

/* edpq_pkg.sv */
// types for the edge delay and pulse qualifier
`default_nettype none
package edpq_pkg;
    typedef enum logic [1:0] {
        EDPQ_ST_START,
        EDPQ_ST_IDLE,
        EDPQ_ST_TIMING
    } edpq_state_t;
endpackage : edpq_pkg
`default_nettype wire

/* edpq_code_filter.sv */
// ratio code settling filter: adopts a new code only once stable
`timescale 1ns/1ps
`default_nettype none
`include "edpq_params.svh"
module edpq_code_filter (
    // clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst_n,
    // master tick and raw code
    input  wire logic                     i_tick,
    input  wire logic [`EDPQ_CODE_W-1:0]  i_code,
    // settled code
    output logic      [`EDPQ_CODE_W-1:0]  o_code
);
    logic [`EDPQ_CODE_W-1:0] cand;
    logic [`EDPQ_FILT_W-1:0] cnt;
    logic [`EDPQ_CODE_W-1:0] diff;
    logic [`EDPQ_FILT_W-1:0] need;

    assign diff = (cand > o_code) ? cand - o_code : o_code - cand;
    assign need = `EDPQ_FILT_W'(`EDPQ_FILT_MULT * (diff + `EDPQ_FILT_BASE));

    // any wobble restarts the wait, so no intermediate code is adopted
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cand <= '0;
            cnt  <= '0;
        end else if (i_code != cand) begin
            cand <= i_code;
            cnt  <= '0;
        end else if (i_tick && cand != o_code) begin
            cnt <= cnt + 1'b1;
        end else if (cand == o_code) begin
            cnt <= '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_code <= '0;
        end else if (i_code == cand && cand != o_code && i_tick && cnt + 1'b1 >= need) begin
            o_code <= cand;
        end
    end
endmodule : edpq_code_filter
`default_nettype wire

/* edpq_top.sv */
// edge delay and pulse qualifier timer
// Functional notes
// - a 4-bit ratio code from the ratio-select input sets both polarity and divide ratio.
// - the ratio code msb is polarity_select.
// - single-edge variant delays rising edges at polarity 0 and falling edges at polarity 1.
// - dual-edge variant delays both edges and polarity 1 inverts the output.
// - the divider offers ratios 1, 8, 64, 512, 4096, 2^15, 2^18 and 2^21.
// - codes 0..7 rise from 1 to 2^21 and codes 8..15 mirror them down to 1.
// - the delay equals the ratio times one master period.
// - timing starts only on a delayed-type edge and a delayed edge moves the output only when timing expires.
// - the master period is never shorter than one microsecond.
// - while the programming current is too low the pending delayed edge is withheld.
// - single-edge: if the input reverts early the output holds and timing restarts at zero.
// - single-edge: the non-delayed edge passes at once and cancels timing.
// - after reset the output is low for 500 master periods, then copies the input.
// - a changed code is adopted after 16*(difference+6) master periods, never via other codes.
`timescale 1ns/1ps
`default_nettype none
`include "edpq_params.svh"
module edpq_top #(
    parameter bit DUAL_EDGE = 1'b0
) (
    // clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    // master oscillator tick and programming current status
    input  wire logic                    i_master_tick,
    input  wire logic                    i_set_current_ok,
    // configuration
    input  wire logic [`EDPQ_CODE_W-1:0] i_ratio_code,
    // logic input and output
    input  wire logic                    i_sig,
    output logic                         o_sig,
    // status
    output logic                         o_polarity_select,
    output logic                         o_busy
);
    logic                    rst_meta;
    logic                    rst_n;
    logic [`EDPQ_CODE_W-1:0] ratio_code;
    logic                    polarity_select;
    logic [`EDPQ_CNT_W-1:0]  target;
    logic [`EDPQ_CNT_W-1:0]  cnt;
    logic [2:0]              ratio_idx;
    logic                    tick;
    logic [7:0]              tick_gap;
    logic                    view;
    logic                    expired;
    edpq_pkg::edpq_state_t   state;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ticks closer than the minimum master period are dropped
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_gap <= '0;
        end else if (tick) begin
            tick_gap <= 8'h01;
        end else if (tick_gap != 8'hFF) begin
            tick_gap <= tick_gap + 8'h01;
        end
    end
    assign tick = i_master_tick && (tick_gap == 8'h00 || tick_gap >= 8'(`EDPQ_MIN_TICK_CYC));

    edpq_code_filter u_filter (
        .i_core_clk (i_core_clk),
        .i_rst_n    (rst_n),
        .i_tick     (tick),
        .i_code     (i_ratio_code),
        .o_code     (ratio_code)
    );

    assign polarity_select = ratio_code[`EDPQ_POL_BIT];
    // mirrored ladder: codes 8..15 count down the same ratios
    assign ratio_idx = polarity_select ? ~ratio_code[2:0] : ratio_code[2:0];
    assign target = `EDPQ_CNT_W'(1) << (3 * ratio_idx);

    // the level the output would show for the current input
    assign view = (DUAL_EDGE && polarity_select) ? ~i_sig : i_sig;
    assign expired = tick && (cnt + 1'b1 >= target);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= edpq_pkg::EDPQ_ST_START;
        end else begin
            unique case (state)
                edpq_pkg::EDPQ_ST_START: begin
                    if (tick && cnt + 1'b1 >= `EDPQ_START_TICKS) begin
                        state <= edpq_pkg::EDPQ_ST_IDLE;
                    end
                end
                edpq_pkg::EDPQ_ST_IDLE: begin
                    if (view != o_sig && (DUAL_EDGE || view != polarity_select)) begin
                        state <= edpq_pkg::EDPQ_ST_TIMING;
                    end
                end
                edpq_pkg::EDPQ_ST_TIMING: begin
                    if (view == o_sig) begin
                        state <= edpq_pkg::EDPQ_ST_IDLE;
                    end else if (expired && i_set_current_ok) begin
                        state <= edpq_pkg::EDPQ_ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (state == edpq_pkg::EDPQ_ST_START) begin
            cnt <= (tick && cnt + 1'b1 >= `EDPQ_START_TICKS) ? '0 : cnt + `EDPQ_CNT_W'(tick);
        end else if (state != edpq_pkg::EDPQ_ST_TIMING || view == o_sig) begin
            cnt <= '0;
        end else if (tick && cnt + 1'b1 < target) begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sig <= 1'b0;
        end else if (state == edpq_pkg::EDPQ_ST_START) begin
            if (tick && cnt + 1'b1 >= `EDPQ_START_TICKS) begin
                o_sig <= view;
            end
        end else if (!DUAL_EDGE && view != o_sig && view == polarity_select) begin
            o_sig <= view;
        end else if (state == edpq_pkg::EDPQ_ST_TIMING && view != o_sig && expired && i_set_current_ok) begin
            o_sig <= view;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_polarity_select <= 1'b0;
            o_busy            <= 1'b0;
        end else begin
            o_polarity_select <= polarity_select;
            o_busy            <= (state == edpq_pkg::EDPQ_ST_TIMING);
        end
    end

    property p_start_low;
        @(posedge i_core_clk) disable iff (!rst_n)
        state == edpq_pkg::EDPQ_ST_START |-> !o_sig;
    endproperty
    a_start_low: assert property (p_start_low) else $error("output not low during start");

    property p_no_early_move;
        @(posedge i_core_clk) disable iff (!rst_n)
        (state == edpq_pkg::EDPQ_ST_TIMING && !expired && view != o_sig
            && (DUAL_EDGE || view != polarity_select)) |=> $stable(o_sig);
    endproperty
    a_no_early_move: assert property (p_no_early_move) else $error("output moved before delay");

    property p_withheld;
        @(posedge i_core_clk) disable iff (!rst_n)
        (state == edpq_pkg::EDPQ_ST_TIMING && !i_set_current_ok && view != o_sig) |=> $stable(o_sig);
    endproperty
    a_withheld: assert property (p_withheld) else $error("edge released with low current");

    property p_fast_edge;
        @(posedge i_core_clk) disable iff (!rst_n)
        (!DUAL_EDGE && state != edpq_pkg::EDPQ_ST_START && view == polarity_select && view != o_sig)
            |=> o_sig == $past(view);
    endproperty
    a_fast_edge: assert property (p_fast_edge) else $error("undelayed edge not passed");

    property p_cancel_clear;
        @(posedge i_core_clk) disable iff (!rst_n)
        (state == edpq_pkg::EDPQ_ST_TIMING && view == o_sig) |=> cnt == '0;
    endproperty
    a_cancel_clear: assert property (p_cancel_clear) else $error("counter not cleared on cancel");

    property p_target_mirror;
        @(posedge i_core_clk) disable iff (!rst_n)
        target == (`EDPQ_CNT_W'(1) << (3 * (ratio_code[`EDPQ_POL_BIT] ? 3'(15 - ratio_code) : ratio_code[2:0])));
    endproperty
    a_target_mirror: assert property (p_target_mirror) else $error("ratio ladder wrong");

    property p_pol_out;
        @(posedge i_core_clk) disable iff (!rst_n)
        1'b1 |=> o_polarity_select == $past(ratio_code[`EDPQ_POL_BIT]);
    endproperty
    a_pol_out: assert property (p_pol_out) else $error("polarity output wrong");

    // a code adopted mid-delay may shrink the target below the count; that delay then ends on the next tick
    property p_cnt_bound;
        @(posedge i_core_clk) disable iff (!rst_n)
        (state == edpq_pkg::EDPQ_ST_TIMING && cnt < target) |=> (cnt < target || $changed(ratio_code));
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("counter past target");
endmodule : edpq_top
`default_nettype wire

/* edpq_switch.sv */
// bouncing switch model that drives the logic input
`timescale 1ns/1ps
`default_nettype none
module edpq_switch (
    // clock
    input  wire logic       i_core_clk,
    // commanded contact level and chatter length
    input  wire logic       i_level,
    input  wire logic [1:0] i_bounce,
    // contact output
    output logic            o_sig
);
    logic       last = 1'h0;
    logic [2:0] left = 3'h0;
    // chatter lasts a few cycles only, well inside one master tick, so it must be swallowed
    always @(posedge i_core_clk) begin
        if (i_level !== last) begin
            last  <= i_level;
            left  <= {i_bounce, 1'h0} - {2'h0, |i_bounce};
            o_sig <= #1 (i_bounce != 2'h0) ? ~i_level : i_level;
        end else if (left != 3'h0) begin
            left  <= left - 3'h1;
            o_sig <= #1 (left[0] ? last : ~last);
        end else begin
            o_sig <= #1 last;
        end
    end
endmodule : edpq_switch
`default_nettype wire

/* tb.sv */
// self-checking bench for the edge delay and pulse qualifier
`timescale 1ns/1ps
`default_nettype none
`include "edpq_params.svh"
module tb;
    logic                    core_clk;
    logic                    rst_n;
    logic                    tick = 1'h0;
    logic [4:0]              tick_cnt = 5'h00;
    logic                    cur_ok;
    logic [`EDPQ_CODE_W-1:0] ratio_code;
    logic                    sw_level;
    logic [1:0]              sw_bounce;
    logic                    sig_in;
    logic                    sig_s;
    logic                    sig_d;
    logic                    pol_s;
    logic                    busy_s;
    int                      fails;
    int                      n_compared;
    // row nibbles: {level, current ok, bounce}, ticks, {single, dual, busy, dual checked}
    logic [11:0] rows [14] = '{12'h605, 12'h471, 12'hF63, 12'hC03, 12'hC0D, 12'h525, 12'hC47,
                               12'h405, 12'hC67, 12'hC07, 12'hC0D, 12'h405, 12'h897, 12'hC1D};
    edpq_switch edpq_switch_i (.i_core_clk(core_clk), .i_level(sw_level), .i_bounce(sw_bounce), .o_sig(sig_in));
    edpq_top #(.DUAL_EDGE(1'b0)) edpq_top_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_master_tick(tick),
        .i_set_current_ok(cur_ok), .i_ratio_code(ratio_code), .i_sig(sig_in), .o_sig(sig_s),
        .o_polarity_select(pol_s), .o_busy(busy_s));
    edpq_top #(.DUAL_EDGE(1'b1)) edpq_top_dual_i (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_master_tick(tick),
        .i_set_current_ok(cur_ok), .i_ratio_code(ratio_code), .i_sig(sig_in), .o_sig(sig_d),
        .o_polarity_select(), .o_busy());
    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end
    // one tick every 25 cycles, the shortest master period the design accepts
    always @(posedge core_clk) begin
        tick_cnt <= #1 (tick_cnt == 5'h18) ? 5'h00 : tick_cnt + 5'h01;
        tick     <= #1 (tick_cnt == 5'h17);
    end
    task automatic complete_run();
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : check
    task automatic wait_ticks(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge core_clk);
                k++;
            end while (tick !== 1'h1 && k < 30);
            if (k >= 30) begin
                fails++;
                complete_run();
            end
        end
    endtask : wait_ticks
    // one tick first, then drive just after it, so chatter never overlaps a tick
    task automatic run_row(input logic [11:0] r);
        wait_ticks(1);
        #1;
        sw_level  = r[11];
        cur_ok    = r[10];
        sw_bounce = r[9:8];
        wait_ticks(int'(r[7:4]));
        repeat (10) @(posedge core_clk);
        #1;
        check(sig_s, r[3], "single-edge output");
        check(busy_s, r[1], "busy flag");
        if (r[0]) begin
            check(sig_d, r[2], "dual-edge output");
        end
    endtask : run_row
    initial begin
        fails      = 0;
        n_compared = 0;
        rst_n      = 1'h0;
        cur_ok     = 1'h1;
        ratio_code = 4'h1;
        sw_level   = 1'h1;
        sw_bounce  = 2'h0;
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        wait_ticks(400);
        #1;
        check(sig_s, 1'h0, "output low in start period");
        check(sig_d, 1'h0, "dual output low in start period");
        wait_ticks(110);
        repeat (10) @(posedge core_clk);
        #1;
        check(sig_s, 1'h1, "input copied after start");
        check(sig_d, 1'h1, "dual input copied after start");
        check(pol_s, 1'h0, "polarity of code 1");
        for (int i = 0; i < 14; i++) begin
            run_row(rows[i]);
        end
        wait_ticks(1);
        #1;
        ratio_code = 4'hF;
        wait_ticks(300);
        #1;
        check(pol_s, 1'h0, "code adopted too early");
        wait_ticks(30);
        repeat (3) @(posedge core_clk);
        #1;
        check(pol_s, 1'h1, "code 15 not adopted");
        run_row(12'h40A);
        run_row(12'h405);
        run_row(12'hC0D);
        run_row(12'hC09);
        rst_n = 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        check(sig_s, 1'h0, "output low in reset");
        check(sig_d, 1'h0, "dual output low in reset");
        check(busy_s, 1'h0, "busy low in reset");
        rst_n = 1'h1;
        wait_ticks(20);
        #1;
        check(sig_s, 1'h0, "input not ignored in start after reset");
        check(sig_d, 1'h0, "dual input not ignored in start after reset");
        check(busy_s, 1'h0, "busy during start after reset");
        complete_run();
    end
endmodule : tb
`default_nettype wire
